//--- logic/mpf_regs.svh
// Register offsets, field positions and reset values of the MAC packet FIFO block.
`ifndef MPF_REGS_SVH
`define MPF_REGS_SVH

`define MPF_OFF_RX_DATA   5'h00
`define MPF_OFF_RX_CTRL   5'h02
`define MPF_OFF_RX_STAT   5'h03
`define MPF_OFF_RX_GOOD   5'h04
`define MPF_OFF_RX_DROP   5'h06
`define MPF_OFF_RX_CRC    5'h08
`define MPF_OFF_RX_VEC    5'h0a
`define MPF_OFF_TX_DATA   5'h10
`define MPF_OFF_TX_CTRL   5'h12
`define MPF_OFF_TX_STAT   5'h13
`define MPF_OFF_TX_GOOD   5'h14
`define MPF_OFF_TX_FAULT  5'h16
`define MPF_OFF_TX_VEC    5'h18
`define MPF_OFF_PAUSE     5'h1c

`define MPF_RXC_RESET     2
`define MPF_TXC_AVAIL     0
`define MPF_TXC_EOF       1
`define MPF_TXC_RESET     2
`define MPF_TXC_CTRLFRM   3
`define MPF_TXC_PAUSE     4
`define MPF_VEC_IGNORED   26
`define MPF_VEC_CRC       25
`define MPF_TX_CTRL_RST   8'h00
`define MPF_FIFO_DEPTH    4

`endif

//--- logic/mpf_pkg.sv
// Types shared by the MAC packet FIFO block.
`default_nettype none
package mpf_pkg;

  // One queue entry: data byte with its end-of-frame marker above it.
  typedef struct packed {
    logic       eof;
    logic [7:0] data;
  } mpf_qword_t;

  // Statistics vector as four bytes, first byte in the top bits.
  typedef struct packed {
    logic [7:0] b0;
    logic [7:0] b1;
    logic [7:0] b2;
    logic [7:0] b3;
  } mpf_svec_t;

endpackage : mpf_pkg
`default_nettype wire

//--- logic/mpf_top.sv
// MAC packet FIFO block: queues, event counters and the CPU register file.
`timescale 1ns/100ps
`default_nettype none
`include "mpf_regs.svh"

// -----------------------------------------------------------------------------
// Queue with valid and ready on both sides, first word falls through.
// -----------------------------------------------------------------------------
module mpf_queue #(
  parameter int W = 9,
  parameter int D = `MPF_FIFO_DEPTH
) (
  input  wire logic         i_clk,
  input  wire logic         i_rst_n,
  input  wire logic         i_clr,
  input  wire logic         i_wvalid,
  output logic              o_wready,
  input  wire logic [W-1:0] i_wdata,
  output logic              o_rvalid,
  input  wire logic         i_rready,
  output logic [W-1:0]      o_rdata
);
  localparam int AW = (D > 1) ? $clog2(D) : 1;
  localparam int CW = $clog2(D + 1);

  logic [W-1:0]  mem_q [D];
  logic [AW-1:0] wp_q;
  logic [AW-1:0] rp_q;
  logic [CW-1:0] cnt_q;
  logic          push;
  logic          pop;

  assign o_wready = (cnt_q != CW'(D));
  assign o_rvalid = (cnt_q != '0);
  assign o_rdata  = mem_q[rp_q];
  assign push     = i_wvalid && o_wready;
  assign pop      = i_rready && o_rvalid;

  always_ff @(posedge i_clk) begin
    if (push) begin
      mem_q[wp_q] <= i_wdata;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n || i_clr) begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wp_q <= (wp_q == AW'(D - 1)) ? '0 : wp_q + 1'b1;
      end
      if (pop) begin
        rp_q <= (rp_q == AW'(D - 1)) ? '0 : rp_q + 1'b1;
      end
      cnt_q <= cnt_q + CW'(push) - CW'(pop);
    end
  end
endmodule : mpf_queue

// -----------------------------------------------------------------------------
// Sixteen-bit event counter.
// -----------------------------------------------------------------------------
module mpf_evcnt #(
  parameter int W = 16
) (
  input  wire logic    i_clk,
  input  wire logic    i_rst_n,
  input  wire logic    i_inc,
  output logic [W-1:0] o_val
);
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_val <= '0;
    end else if (i_inc) begin
      o_val <= o_val + 1'b1;
    end
  end
endmodule : mpf_evcnt

// -----------------------------------------------------------------------------
// Top level.
// -----------------------------------------------------------------------------
module mpf_top
  import mpf_pkg::*;
#(
  parameter int DEPTH = `MPF_FIFO_DEPTH
) (
  input  wire logic        I_MCLK,
  input  wire logic        I_RST_N,
  input  wire logic [4:0]  I_ADDR,
  input  wire logic        I_WR,
  input  wire logic        I_RD,
  input  wire logic [7:0]  I_WDATA,
  output logic [7:0]       O_RDATA,
  input  wire logic        I_RX_WE,
  input  wire logic [7:0]  I_RX_DATA,
  input  wire logic        I_RX_EOF,
  input  wire logic        I_RX_ERROR,
  input  wire logic        I_RX_STAT_EN,
  input  wire logic [31:0] I_RX_STAT_VEC,
  output logic             O_RX_READY,
  output logic             O_RX_IGNORE,
  input  wire logic        I_TX_RD,
  output logic             O_TX_AVAIL,
  output logic [7:0]       O_TX_DATA,
  output logic             O_TX_EOF,
  output logic             O_TX_EMPTY,
  input  wire logic        I_TX_DONE,
  input  wire logic        I_TX_DISCFRM,
  input  wire logic        I_TX_STAT_EN,
  input  wire logic [31:0] I_TX_STAT_VEC,
  output logic             O_CTRL_FRAME,
  output logic             O_PAUSE_REQ,
  output logic [15:0]      O_PAUSE_TIME
);
  mpf_qword_t  rx_in;
  mpf_qword_t  rx_head;
  mpf_qword_t  tx_in;
  mpf_qword_t  tx_head;
  mpf_svec_t   rx_vec_q;
  mpf_svec_t   tx_vec_q;
  logic        rx_valid;
  logic        rx_pop;
  logic        rx_clr;
  logic        tx_wready;
  logic        tx_valid;
  logic        tx_push;
  logic        tx_clr;
  logic        rx_eof_q;
  logic        rx_err_q;
  logic        pkt_avail_q;
  logic        tx_err_q;
  logic        tx_done_q;
  logic        avail_wr;
  logic [7:0]  tx_ctrl_q;
  logic [15:0] pause_q;
  logic [15:0] rx_good;
  logic [15:0] rx_drop;
  logic [15:0] rx_crc;
  logic [15:0] tx_good;
  logic [15:0] tx_fault;
  logic [7:0]  rx_stat;
  logic [7:0]  tx_stat;
  logic [7:0]  rd_d;

  // ---------------------------------------------------------------------------
  // Receive queue.
  // ---------------------------------------------------------------------------
  assign rx_in.data = I_RX_DATA;
  assign rx_in.eof  = I_RX_EOF;
  assign rx_pop = I_RD && (I_ADDR == `MPF_OFF_RX_DATA) && rx_valid;
  assign rx_clr = I_WR && (I_ADDR == `MPF_OFF_RX_CTRL) && I_WDATA[`MPF_RXC_RESET];

  mpf_queue #(.W(9), .D(DEPTH)) u_rxq (
    .i_clk    (I_MCLK),
    .i_rst_n  (I_RST_N),
    .i_clr    (rx_clr),
    .i_wvalid (I_RX_WE),
    .o_wready (O_RX_READY),
    .i_wdata  (rx_in),
    .o_rvalid (rx_valid),
    .i_rready (rx_pop),
    .o_rdata  (rx_head)
  );

  // End-of-frame of the byte just read, so software sees it beside the data.
  always_ff @(posedge I_MCLK) begin
    if (!I_RST_N || rx_clr) begin
      rx_eof_q <= 1'b0;
    end else if (rx_pop) begin
      rx_eof_q <= rx_head.eof;
    end
  end

  always_ff @(posedge I_MCLK) begin
    if (!I_RST_N) begin
      rx_err_q <= 1'b0;
    end else if (I_RX_ERROR) begin
      rx_err_q <= 1'b1;
    end else if (rx_clr) begin
      rx_err_q <= 1'b0;
    end
  end

  // A new packet end wins over the empty-queue clear.
  always_ff @(posedge I_MCLK) begin
    if (!I_RST_N) begin
      pkt_avail_q <= 1'b0;
    end else if (I_RX_WE && O_RX_READY && I_RX_EOF) begin
      pkt_avail_q <= 1'b1;
    end else if (!rx_valid || rx_clr) begin
      pkt_avail_q <= 1'b0;
    end
  end

  assign O_RX_IGNORE = pkt_avail_q;

  always_ff @(posedge I_MCLK) begin
    if (!I_RST_N) begin
      rx_vec_q <= '0;
    end else if (I_RX_STAT_EN) begin
      rx_vec_q <= I_RX_STAT_VEC;
    end
  end

  mpf_evcnt u_rx_good (
    .i_clk   (I_MCLK),
    .i_rst_n (I_RST_N),
    .i_inc   (I_RX_WE && O_RX_READY && I_RX_EOF && !I_RX_ERROR),
    .o_val   (rx_good)
  );

  mpf_evcnt u_rx_drop (
    .i_clk   (I_MCLK),
    .i_rst_n (I_RST_N),
    .i_inc   (I_RX_STAT_EN && I_RX_STAT_VEC[`MPF_VEC_IGNORED]),
    .o_val   (rx_drop)
  );

  mpf_evcnt u_rx_crc (
    .i_clk   (I_MCLK),
    .i_rst_n (I_RST_N),
    .i_inc   (I_RX_STAT_EN && I_RX_STAT_VEC[`MPF_VEC_CRC]),
    .o_val   (rx_crc)
  );

  assign rx_stat = {2'b00, !O_RX_READY, !rx_valid, rx_err_q, 1'b0, rx_eof_q, pkt_avail_q};

  // ---------------------------------------------------------------------------
  // Transmit queue.
  // ---------------------------------------------------------------------------
  assign tx_in.data = I_WDATA;
  assign tx_in.eof  = tx_ctrl_q[`MPF_TXC_EOF];
  assign tx_push  = I_WR && (I_ADDR == `MPF_OFF_TX_DATA) && tx_wready;
  assign tx_clr   = I_WR && (I_ADDR == `MPF_OFF_TX_CTRL) && I_WDATA[`MPF_TXC_RESET];
  assign avail_wr = I_WR && (I_ADDR == `MPF_OFF_TX_CTRL) && I_WDATA[`MPF_TXC_AVAIL];

  mpf_queue #(.W(9), .D(DEPTH)) u_txq (
    .i_clk    (I_MCLK),
    .i_rst_n  (I_RST_N),
    .i_clr    (tx_clr),
    .i_wvalid (tx_push),
    .o_wready (tx_wready),
    .i_wdata  (tx_in),
    .o_rvalid (tx_valid),
    .i_rready (I_TX_RD && O_TX_AVAIL),
    .o_rdata  (tx_head)
  );

  assign O_TX_AVAIL   = tx_ctrl_q[`MPF_TXC_AVAIL] && tx_valid;
  assign O_TX_DATA    = tx_head.data;
  assign O_TX_EOF     = tx_head.eof;
  assign O_TX_EMPTY   = !tx_valid;
  assign O_CTRL_FRAME = tx_ctrl_q[`MPF_TXC_CTRLFRM];
  assign O_PAUSE_REQ  = tx_ctrl_q[`MPF_TXC_PAUSE];
  assign O_PAUSE_TIME = pause_q;

  // The queue reset bit is a pulse and reads back as zero; a software
  // packet-ready write wins over the clear by the MAC done.
  always_ff @(posedge I_MCLK) begin
    if (!I_RST_N) begin
      tx_ctrl_q <= `MPF_TX_CTRL_RST;
    end else if (I_WR && (I_ADDR == `MPF_OFF_TX_CTRL)) begin
      tx_ctrl_q <= I_WDATA & 8'hfb;
    end else if (I_TX_DONE) begin
      tx_ctrl_q[`MPF_TXC_AVAIL] <= 1'b0;
    end
  end

  always_ff @(posedge I_MCLK) begin
    if (!I_RST_N) begin
      pause_q <= '0;
    end else if (I_WR && (I_ADDR == `MPF_OFF_PAUSE)) begin
      pause_q[15:8] <= I_WDATA;
    end else if (I_WR && (I_ADDR == (`MPF_OFF_PAUSE + 5'h01))) begin
      pause_q[7:0] <= I_WDATA;
    end
  end

  always_ff @(posedge I_MCLK) begin
    if (!I_RST_N) begin
      tx_done_q <= 1'b0;
      tx_err_q  <= 1'b0;
    end else begin
      if (I_TX_DONE) begin
        tx_done_q <= 1'b1;
      end else if (avail_wr || tx_clr) begin
        tx_done_q <= 1'b0;
      end
      if (I_TX_DISCFRM) begin
        tx_err_q <= 1'b1;
      end else if (avail_wr || tx_clr) begin
        tx_err_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge I_MCLK) begin
    if (!I_RST_N) begin
      tx_vec_q <= '0;
    end else if (I_TX_STAT_EN) begin
      tx_vec_q <= I_TX_STAT_VEC;
    end
  end

  mpf_evcnt u_tx_good (
    .i_clk   (I_MCLK),
    .i_rst_n (I_RST_N),
    .i_inc   (I_TX_DONE),
    .o_val   (tx_good)
  );

  mpf_evcnt u_tx_fault (
    .i_clk   (I_MCLK),
    .i_rst_n (I_RST_N),
    .i_inc   (I_TX_DISCFRM),
    .o_val   (tx_fault)
  );

  assign tx_stat = {4'h0, !tx_valid, !tx_wready, tx_err_q, tx_done_q && !tx_valid};

  // ---------------------------------------------------------------------------
  // Read data, registered one cycle after the read strobe.
  // ---------------------------------------------------------------------------
  always_comb begin
    rd_d = 8'h00;
    if (I_ADDR == `MPF_OFF_RX_DATA) begin
      rd_d = rx_valid ? rx_head.data : 8'h00;
    end else if (I_ADDR == `MPF_OFF_RX_STAT) begin
      rd_d = rx_stat;
    end else if (I_ADDR == `MPF_OFF_RX_GOOD) begin
      rd_d = rx_good[15:8];
    end else if (I_ADDR == `MPF_OFF_RX_GOOD + 5'h01) begin
      rd_d = rx_good[7:0];
    end else if (I_ADDR == `MPF_OFF_RX_DROP) begin
      rd_d = rx_drop[15:8];
    end else if (I_ADDR == `MPF_OFF_RX_DROP + 5'h01) begin
      rd_d = rx_drop[7:0];
    end else if (I_ADDR == `MPF_OFF_RX_CRC) begin
      rd_d = rx_crc[15:8];
    end else if (I_ADDR == `MPF_OFF_RX_CRC + 5'h01) begin
      rd_d = rx_crc[7:0];
    end else if (I_ADDR == `MPF_OFF_RX_VEC) begin
      rd_d = rx_vec_q.b0;
    end else if (I_ADDR == `MPF_OFF_RX_VEC + 5'h01) begin
      rd_d = rx_vec_q.b1;
    end else if (I_ADDR == `MPF_OFF_RX_VEC + 5'h02) begin
      rd_d = rx_vec_q.b2;
    end else if (I_ADDR == `MPF_OFF_RX_VEC + 5'h03) begin
      rd_d = rx_vec_q.b3;
    end else if (I_ADDR == `MPF_OFF_TX_CTRL) begin
      rd_d = tx_ctrl_q;
    end else if (I_ADDR == `MPF_OFF_TX_STAT) begin
      rd_d = tx_stat;
    end else if (I_ADDR == `MPF_OFF_TX_GOOD) begin
      rd_d = tx_good[15:8];
    end else if (I_ADDR == `MPF_OFF_TX_GOOD + 5'h01) begin
      rd_d = tx_good[7:0];
    end else if (I_ADDR == `MPF_OFF_TX_FAULT) begin
      rd_d = tx_fault[15:8];
    end else if (I_ADDR == `MPF_OFF_TX_FAULT + 5'h01) begin
      rd_d = tx_fault[7:0];
    end else if (I_ADDR == `MPF_OFF_TX_VEC) begin
      rd_d = tx_vec_q.b0;
    end else if (I_ADDR == `MPF_OFF_TX_VEC + 5'h01) begin
      rd_d = tx_vec_q.b1;
    end else if (I_ADDR == `MPF_OFF_TX_VEC + 5'h02) begin
      rd_d = tx_vec_q.b2;
    end else if (I_ADDR == `MPF_OFF_TX_VEC + 5'h03) begin
      rd_d = tx_vec_q.b3;
    end else if (I_ADDR == `MPF_OFF_PAUSE) begin
      rd_d = pause_q[15:8];
    end else if (I_ADDR == `MPF_OFF_PAUSE + 5'h01) begin
      rd_d = pause_q[7:0];
    end
  end

  always_ff @(posedge I_MCLK) begin
    if (!I_RST_N) begin
      O_RDATA <= 8'h00;
    end else if (I_RD) begin
      O_RDATA <= rd_d;
    end
  end

  // ---------------------------------------------------------------------------
  // Checks.
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge I_MCLK); endclocking
  default disable iff (!I_RST_N);

  a_rx_byte_read: assert property (
    rx_pop |=> (O_RDATA == $past(rx_head.data)) && (rx_eof_q == $past(rx_head.eof)))
    else $error("receive byte read returned wrong data");
  a_rx_queue_clr: assert property (
    rx_clr |=> !rx_valid && O_RX_READY)
    else $error("receive queue not cleared");
  a_rx_full_flag: assert property (
    $rose(rx_stat[5]) |-> $past(I_RX_WE && O_RX_READY) && !rx_stat[4])
    else $error("full flag rose without a stored byte");
  a_rx_avail_set: assert property (
    (I_RX_WE && O_RX_READY && I_RX_EOF) |=> pkt_avail_q && O_RX_IGNORE)
    else $error("packet available not set on frame end");
  a_rx_avail_clr: assert property (
    (!rx_valid && !I_RX_WE) |=> !pkt_avail_q)
    else $error("packet available not cleared on empty queue");
  a_drop_count_step: assert property (
    (I_RX_STAT_EN && I_RX_STAT_VEC[`MPF_VEC_IGNORED]) |=> rx_drop == $past(rx_drop) + 16'h0001)
    else $error("drop counter missed an event");
  a_tx_store_eof: assert property (
    (tx_push && !tx_valid) |=> tx_valid && O_TX_DATA == $past(I_WDATA) && O_TX_EOF == $past(tx_ctrl_q[1]))
    else $error("transmit entry not stored");
  a_tx_avail_gate: assert property (
    (I_TX_RD && !O_TX_AVAIL && tx_valid && !tx_clr) |=>
      tx_valid && O_TX_DATA == $past(O_TX_DATA) && O_TX_EOF == $past(O_TX_EOF))
    else $error("transmit queue popped without packet ready");
  a_tx_sent_step: assert property (
    I_TX_DONE |=> tx_good == $past(tx_good) + 16'h0001 ##1 tx_good == $past(tx_good))
    else $error("sent counter misstep");
  a_tx_vec_latch: assert property (
    I_TX_STAT_EN |=> tx_vec_q == $past(I_TX_STAT_VEC))
    else $error("transmit statistics not latched");
endmodule : mpf_top
`default_nettype wire

//--- dv/mpf_mac_model.sv
// Behavioural model of the MAC core facing the packet FIFO block.
`timescale 1ns/100ps
`default_nettype none
module mpf_mac_model (
  input  wire logic        clk,
  input  wire logic        tx_avail,
  input  wire logic [7:0]  tx_data,
  input  wire logic        tx_eof,
  output logic             rx_we,
  output logic [7:0]       rx_data,
  output logic             rx_eof,
  output logic             rx_error,
  output logic             rx_stat_en,
  output logic [31:0]      rx_stat_vec,
  output logic             tx_rd,
  output logic             tx_done,
  output logic             tx_discfrm,
  output logic             tx_stat_en,
  output logic [31:0]      tx_stat_vec
);
  logic [8:0] popped[$];
  logic       slow = 1'b0;
  logic       ph = 1'b0;
  logic       eof_seen = 1'b0;
  int         n_done = 0;

  initial begin
    {rx_we, rx_data, rx_eof, rx_error, rx_stat_en, rx_stat_vec} = '0;
    {tx_rd, tx_done, tx_discfrm, tx_stat_en, tx_stat_vec} = '0;
  end

  // Bytes are taken only while the block offers them, end-of-frame kept with each byte.
  always @(posedge clk) begin
    if (tx_rd && tx_avail) begin
      popped.push_back({tx_eof, tx_data});
      if (tx_eof) eof_seen = 1'b1;
    end
  end

  // The pop request runs regardless of availability so that the block's gating is exercised.
  // Slow mode pops only on every other cycle; done follows the last byte.
  always @(negedge clk) begin
    ph = ~ph;
    tx_rd = !slow || ph;
    tx_done = eof_seen;
    if (eof_seen) n_done++;
    eof_seen = 1'b0;
  end

  // Sends n bytes from b0 upwards; the final byte carries end-of-frame when last is set.
  task rx_pkt(input int n, input logic [7:0] b0, input logic last);
    for (int i = 0; i < n; i++) begin
      @(negedge clk);
      rx_we = 1'b1;
      rx_data = b0 + 8'(i);
      rx_eof = last && (i == n - 1);
    end
    @(negedge clk);
    rx_we = 1'b0;
    rx_data = ~rx_data;
    rx_eof = 1'b0;
  endtask : rx_pkt

  // One-cycle event: 0 rx statistics, 1 tx statistics, 2 rx error, 3 frame discard.
  task pulse(input int which, input logic [31:0] v);
    @(negedge clk);
    case (which)
      0: begin rx_stat_en = 1'b1; rx_stat_vec = v; end
      1: begin tx_stat_en = 1'b1; tx_stat_vec = v; end
      2: rx_error = 1'b1;
      default: tx_discfrm = 1'b1;
    endcase
    @(negedge clk);
    {rx_stat_en, tx_stat_en, rx_error, tx_discfrm} = '0;
    rx_stat_vec = ~v;
    tx_stat_vec = ~v;
  endtask : pulse
endmodule : mpf_mac_model
`default_nettype wire

//--- dv/test_mpf_top.sv
// Self-checking testbench of the MAC packet FIFO block.
`timescale 1ns/100ps
`default_nettype none
`include "mpf_regs.svh"
module test_mpf_top;
  logic        I_MCLK = 1'b0;
  logic        I_RST_N = 1'b0;
  logic [4:0]  I_ADDR = '0;
  logic        I_WR = 1'b0;
  logic        I_RD = 1'b0;
  logic [7:0]  I_WDATA = '0;
  logic [7:0]  O_RDATA;
  logic        rx_we, rx_eof, rx_err, rx_sen, tx_rd, tx_done, tx_disc, tx_sen;
  logic [7:0]  rx_data, tx_data;
  logic [31:0] rx_vec, tx_vec;
  logic        rx_ready, rx_ignore, tx_avail, tx_eof, tx_empty, ctrl_frame, pause_req;
  logic [15:0] pause_time;
  int          miscompares = 0;
  int          n_tests = 0;
  int          cyc = 0;
  logic [31:0] vec;

  always #5 I_MCLK = ~I_MCLK;

  mpf_top mpf_top_inst (
    .I_MCLK(I_MCLK), .I_RST_N(I_RST_N), .I_ADDR(I_ADDR), .I_WR(I_WR), .I_RD(I_RD),
    .I_WDATA(I_WDATA), .O_RDATA(O_RDATA), .I_RX_WE(rx_we), .I_RX_DATA(rx_data), .I_RX_EOF(rx_eof),
    .I_RX_ERROR(rx_err), .I_RX_STAT_EN(rx_sen), .I_RX_STAT_VEC(rx_vec), .O_RX_READY(rx_ready),
    .O_RX_IGNORE(rx_ignore), .I_TX_RD(tx_rd), .O_TX_AVAIL(tx_avail), .O_TX_DATA(tx_data),
    .O_TX_EOF(tx_eof), .O_TX_EMPTY(tx_empty), .I_TX_DONE(tx_done), .I_TX_DISCFRM(tx_disc),
    .I_TX_STAT_EN(tx_sen), .I_TX_STAT_VEC(tx_vec), .O_CTRL_FRAME(ctrl_frame),
    .O_PAUSE_REQ(pause_req), .O_PAUSE_TIME(pause_time));

  mpf_mac_model mpf_mac_model_inst (
    .clk(I_MCLK), .tx_avail(tx_avail), .tx_data(tx_data), .tx_eof(tx_eof), .rx_we(rx_we),
    .rx_data(rx_data), .rx_eof(rx_eof), .rx_error(rx_err), .rx_stat_en(rx_sen),
    .rx_stat_vec(rx_vec), .tx_rd(tx_rd), .tx_done(tx_done), .tx_discfrm(tx_disc),
    .tx_stat_en(tx_sen), .tx_stat_vec(tx_vec));

  // ---------------------------------------------------------------------------
  // Checking and register access.
  // ---------------------------------------------------------------------------
  task summarize();
    $display("Comparisons %0d, mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : summarize

  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task wr(input logic [4:0] a, input logic [7:0] d);
    @(negedge I_MCLK);
    I_ADDR = a;
    I_WDATA = d;
    I_WR = 1'b1;
    @(negedge I_MCLK);
    I_WR = 1'b0;
  endtask : wr

  // Read strobe for one cycle; the registered answer is settled at the next falling edge.
  task rdc(input logic [4:0] a, input logic [7:0] e);
    @(negedge I_MCLK);
    I_ADDR = a;
    I_RD = 1'b1;
    @(negedge I_MCLK);
    I_RD = 1'b0;
    chk($sformatf("register %h", a), {24'h0, O_RDATA}, {24'h0, e});
  endtask : rdc

  always @(posedge I_MCLK) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      summarize();
    end
  end

  // ---------------------------------------------------------------------------
  // Main sequence.
  // ---------------------------------------------------------------------------
  initial begin
    repeat (20) @(negedge I_MCLK);
    I_RST_N = 1'b1;
    rdc(`MPF_OFF_RX_STAT, 8'h10);
    rdc(`MPF_OFF_TX_STAT, 8'h08);
    rdc(`MPF_OFF_RX_CTRL, 8'h00);
    rdc(5'h01, 8'h00);
    for (int i = 0; i < 6; i++) rdc(5'(`MPF_OFF_RX_GOOD + i), 8'h00);
    for (int i = 0; i < 4; i++) rdc(5'(`MPF_OFF_TX_GOOD + i), 8'h00);
    // One three-byte packet drained by the CPU.
    mpf_mac_model_inst.rx_pkt(3, 8'h40, 1'b1);
    rdc(`MPF_OFF_RX_STAT, 8'h01);
    chk("rx ignore", {31'h0, rx_ignore}, 32'h1);
    rdc(`MPF_OFF_RX_GOOD, 8'h00);
    rdc(`MPF_OFF_RX_GOOD + 5'h1, 8'h01);
    for (int i = 0; i < 3; i++) begin
      rdc(`MPF_OFF_RX_DATA, 8'h40 + 8'(i));
      rdc(`MPF_OFF_RX_STAT, (i == 2) ? 8'h12 : 8'h01);
    end
    chk("rx ignore", {31'h0, rx_ignore}, 32'h0);
    rdc(`MPF_OFF_RX_DATA, 8'h00);
    // Receive statistics vector and the drop and checksum counters.
    vec = 32'h04a5_0140;
    mpf_mac_model_inst.pulse(0, vec);
    for (int i = 0; i < 4; i++) rdc(5'(`MPF_OFF_RX_VEC + i), vec[31 - 8 * i -: 8]);
    rdc(`MPF_OFF_RX_DROP + 5'h1, 8'h01);
    rdc(`MPF_OFF_RX_CRC + 5'h1, 8'h00);
    mpf_mac_model_inst.pulse(0, 32'h0200_0040);
    rdc(`MPF_OFF_RX_CRC, 8'h00);
    rdc(`MPF_OFF_RX_CRC + 5'h1, 8'h01);
    rdc(`MPF_OFF_RX_DROP + 5'h1, 8'h01);
    // Error flag, a full queue, then a queue reset.
    mpf_mac_model_inst.pulse(2, 32'h0);
    rdc(`MPF_OFF_RX_STAT, 8'h1a);
    mpf_mac_model_inst.rx_pkt(4, 8'h80, 1'b0);
    rdc(`MPF_OFF_RX_STAT, 8'h2a);
    chk("rx ready", {31'h0, rx_ready}, 32'h0);
    wr(`MPF_OFF_RX_CTRL, 8'h04);
    rdc(`MPF_OFF_RX_STAT, 8'h10);
    // Transmit: fill to the brim, one extra byte is dropped, then a slow drain.
    wr(`MPF_OFF_TX_CTRL, 8'h00);
    for (int i = 1; i < 4; i++) wr(`MPF_OFF_TX_DATA, 8'(8'h11 * i));
    wr(`MPF_OFF_TX_CTRL, 8'h02);
    wr(`MPF_OFF_TX_DATA, 8'h44);
    wr(`MPF_OFF_TX_DATA, 8'h55);
    rdc(`MPF_OFF_TX_STAT, 8'h04);
    chk("tx empty", {31'h0, tx_empty}, 32'h0);
    chk("tx avail", {31'h0, tx_avail}, 32'h0);
    mpf_mac_model_inst.slow = 1'b1;
    wr(`MPF_OFF_TX_CTRL, 8'h01);
    for (int k = 0; k < 200 && mpf_mac_model_inst.n_done == 0; k++) @(negedge I_MCLK);
    chk("pop count", mpf_mac_model_inst.popped.size(), 32'd4);
    for (int i = 0; i < 4; i++)
      chk("pop entry", {23'h0, mpf_mac_model_inst.popped[i]}, {23'h0, i == 3, 8'(8'h11 * (i + 1))});
    rdc(`MPF_OFF_TX_STAT, 8'h09);
    chk("tx empty", {31'h0, tx_empty}, 32'h1);
    rdc(`MPF_OFF_TX_CTRL, 8'h00);
    rdc(`MPF_OFF_TX_GOOD + 5'h1, 8'h01);
    mpf_mac_model_inst.pulse(3, 32'h0);
    rdc(`MPF_OFF_TX_FAULT, 8'h00);
    rdc(`MPF_OFF_TX_FAULT + 5'h1, 8'h01);
    rdc(`MPF_OFF_TX_STAT, 8'h0b);
    vec = 32'h5a3c_0f81;
    mpf_mac_model_inst.pulse(1, vec);
    for (int i = 0; i < 4; i++) rdc(5'(`MPF_OFF_TX_VEC + i), vec[31 - 8 * i -: 8]);
    // Pause request, control frame and pause time.
    wr(`MPF_OFF_TX_CTRL, 8'h18);
    wr(`MPF_OFF_PAUSE, 8'hab);
    wr(`MPF_OFF_PAUSE + 5'h1, 8'hcd);
    chk("pause request", {31'h0, pause_req}, 32'h1);
    chk("control frame", {31'h0, ctrl_frame}, 32'h1);
    chk("pause time", {16'h0, pause_time}, 32'h0000_abcd);
    rdc(`MPF_OFF_TX_CTRL, 8'h18);
    rdc(`MPF_OFF_PAUSE, 8'hab);
    rdc(`MPF_OFF_PAUSE + 5'h1, 8'hcd);
    wr(`MPF_OFF_TX_CTRL, 8'h00);
    chk("pause request", {31'h0, pause_req}, 32'h0);
    // Transmit queue reset empties the queue and clears the done and error flags.
    wr(`MPF_OFF_TX_DATA, 8'h66);
    chk("tx empty", {31'h0, tx_empty}, 32'h0);
    chk("tx avail", {31'h0, tx_avail}, 32'h0);
    rdc(`MPF_OFF_TX_STAT, 8'h02);
    wr(`MPF_OFF_TX_CTRL, 8'h04);
    rdc(`MPF_OFF_TX_STAT, 8'h08);
    chk("tx empty", {31'h0, tx_empty}, 32'h1);
    rdc(`MPF_OFF_TX_CTRL, 8'h00);
    summarize();
  end
endmodule : test_mpf_top
`default_nettype wire
